// File: verilog/fcs_flash_cfg.sv
// Flash configuration block: clock ratio register, working options, key steering and backdoor unlock.
// Assumes an AXI4-Lite master, the option byte and stored key from the array, and a command engine outside.
`include "fcs_regs.svh"
`default_nettype none
module fcs_flash_cfg (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Nonvolatile contents and access source
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [63:0] stored_backdoor_key,
  input wire logic background_debug_commands,
  input wire logic blank_check_pass,
  // Command engine side
  output logic flash_cmd_start,
  output logic [2:0] flash_cmd_index,
  output logic [7:0] flash_cmd_data,
  output logic program_erase_enable,
  output logic flash_clk_pulse,
  // Security and vectors
  output logic secure_block,
  output logic redirect_enable,
  // Interrupt
  output logic irq
);
  logic [6:0] ratio_reg;
  logic ratio_loaded_flag;
  fcs_pkg::fcs_byte_type flash_options_working_reg;
  fcs_pkg::fcs_byte_type flash_config_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [7:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic [2:0] prescale_reg;
  logic [5:0] div_count_reg;
  logic [3:0] key_count_reg;
  fcs_pkg::fcs_key_state_type key_state_reg;
  fcs_pkg::fcs_byte_type key_buf [8];
  logic [1:0] sec_next;
  logic wr_go;
  logic wr_lane0;
  logic key_window;
  logic steer_clear;
  logic key_match;
  logic cmd_write;
  logic key_write;
  logic [2:0] st_set;
  logic bus_tick;
  logic [63:0] key_flat;

  // Decode of the key window: eight word slots in ascending order
  function automatic logic in_key_window(input logic [7:0] a);
    in_key_window = (a >= `FCS_OFS_KEY0) && (a <= `FCS_OFS_KEY7) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `FCS_OFS_RATIO) || (a == `FCS_OFS_OPTIONS) || (a == `FCS_OFS_CONFIG) ||
             (a == `FCS_OFS_STATUS) || (a == `FCS_OFS_MASK) || in_key_window(a);
  endfunction

  // Write channel capture: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end
    else if (wr_go)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (wr_go)
      w_full_reg <= 1'b0;
  end

  // Ready is withheld until the pending pair is answered, so one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      awready <= !aw_full_reg && !(awvalid && awready) && !bvalid;
      wready <= !w_full_reg && !(wvalid && wready) && !bvalid;
    end
  end

  assign wr_go = aw_full_reg && w_full_reg && !bvalid;
  assign wr_lane0 = wr_go && w_strb_reg[0];
  assign key_window = in_key_window(aw_addr_reg);
  assign key_write = wr_lane0 && key_window && flash_config_reg[`FCS_BIT_STEER];
  assign cmd_write = wr_lane0 && key_window && !flash_config_reg[`FCS_BIT_STEER];
  assign steer_clear = wr_lane0 && (aw_addr_reg == `FCS_OFS_CONFIG) &&
                       flash_config_reg[`FCS_BIT_STEER] && !w_data_reg[`FCS_BIT_STEER];

  // Write response, decode error for holes in the map
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `FCS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr_reg) ? `FCS_RESP_OKAY : `FCS_RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Ratio register: only the first write after reset lands, any value sets the flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ratio_reg <= `FCS_RST_RATIO;
      ratio_loaded_flag <= 1'b0;
    end
    else if (wr_lane0 && (aw_addr_reg == `FCS_OFS_RATIO) && !ratio_loaded_flag)
    begin
      ratio_reg <= w_data_reg[6:0];
      ratio_loaded_flag <= 1'b1;
    end
  end

  // Configuration register, only the key steer bit is implemented
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flash_config_reg <= `FCS_RST_CONFIG;
    else if (wr_lane0 && (aw_addr_reg == `FCS_OFS_CONFIG))
      flash_config_reg <= {2'h0, w_data_reg[`FCS_BIT_STEER], 5'h00};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= `FCS_RST_MASK;
    else if (wr_lane0 && (aw_addr_reg == `FCS_OFS_MASK))
      mask_reg <= w_data_reg[2:0];
  end

  // Key collection; debug-sourced bytes are dropped so debug alone cannot unlock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_state_reg <= fcs_pkg::KEY_IDLE;
      key_count_reg <= 4'h0;
    end
    else if (wr_lane0 && (aw_addr_reg == `FCS_OFS_CONFIG))
    begin
      key_state_reg <= w_data_reg[`FCS_BIT_STEER] ? fcs_pkg::KEY_COLLECT : fcs_pkg::KEY_IDLE;
      key_count_reg <= 4'h0;
    end
    else if (key_write && !background_debug_commands)
    begin
      unique case (key_state_reg)
        fcs_pkg::KEY_COLLECT:
        begin
          if ((key_count_reg < `FCS_KEY_BYTES) && (aw_addr_reg[4:2] == key_count_reg[2:0]))
            key_count_reg <= key_count_reg + 4'h1;
          else
            key_state_reg <= fcs_pkg::KEY_BROKEN;
        end
        fcs_pkg::KEY_IDLE, fcs_pkg::KEY_BROKEN:
          key_state_reg <= key_state_reg;
      endcase
    end
  end

  // Key byte store, kept without reset since the count guards use
  always_ff @(posedge aclk)
  begin
    if (key_write && !background_debug_commands && (aw_addr_reg[4:2] == key_count_reg[2:0]))
      key_buf[aw_addr_reg[4:2]] <= w_data_reg[7:0];
  end

  // First written byte compares with the low-addressed stored byte
  always_comb
  begin
    key_flat = 64'h0;
    for (int i = 0; i < 8; i++)
      key_flat[63 - 8 * i -: 8] = key_buf[i];
  end

  // Comparison happens on the write that clears steer, and only with backdoor enabled
  assign key_match = steer_clear && flash_options_working_reg[`FCS_BIT_BACKDOOR] &&
                     (key_state_reg == fcs_pkg::KEY_COLLECT) && (key_count_reg == `FCS_KEY_BYTES) &&
                     (key_flat == stored_backdoor_key);

  // Working options copied while reset is held; later only the security code can move
  always_comb
  begin
    sec_next = flash_options_working_reg[1:0];
    if (key_match || blank_check_pass)
      sec_next = `FCS_SEC_OPEN;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flash_options_working_reg <= nonvolatile_option_byte;
    else
      flash_options_working_reg <= {flash_options_working_reg[7:2], sec_next};
  end

  // secure_block registered from the next code, so it tracks the code field from the first edge out of reset; redirect_enable from the working redirect bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      secure_block <= 1'b1;
      redirect_enable <= 1'b0;
    end
    else
    begin
      secure_block <= (sec_next != `FCS_SEC_OPEN);
      redirect_enable <= !flash_options_working_reg[`FCS_BIT_REDIRECT];
    end
  end

  // Command start: refused with an access error until the ratio is loaded
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_cmd_start <= 1'b0;
      flash_cmd_index <= 3'h0;
      flash_cmd_data <= 8'h00;
      program_erase_enable <= 1'b0;
    end
    else
    begin
      flash_cmd_start <= cmd_write && ratio_loaded_flag;
      program_erase_enable <= ratio_loaded_flag || (wr_lane0 && (aw_addr_reg == `FCS_OFS_RATIO));
      if (cmd_write)
      begin
        flash_cmd_index <= aw_addr_reg[4:2];
        flash_cmd_data <= w_data_reg[7:0];
      end
    end
  end

  // Flash clock: bus clock or bus clock/8, then divide by ratio plus one; idle until loaded
  assign bus_tick = !ratio_reg[`FCS_BIT_PRESCALE] || (prescale_reg == `FCS_PRESCALE_DIV);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ratio_loaded_flag)
    begin
      prescale_reg <= 3'h0;
      div_count_reg <= 6'h00;
      flash_clk_pulse <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_reg + 3'h1;
      flash_clk_pulse <= 1'b0;
      if (bus_tick)
      begin
        if (div_count_reg == 6'h00)
        begin
          div_count_reg <= ratio_reg[5:0];
          flash_clk_pulse <= 1'b1;
        end
        else
          div_count_reg <= div_count_reg - 6'h01;
      end
    end
  end

  // Sticky events: a set in the same cycle as a write-one clear wins
  assign st_set = {steer_clear && !key_match, key_match || blank_check_pass, cmd_write && !ratio_loaded_flag};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= 3'h0;
    else if (wr_lane0 && (aw_addr_reg == `FCS_OFS_STATUS))
      status_reg <= (status_reg & ~w_data_reg[2:0]) | st_set;
    else
      status_reg <= status_reg | st_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |((status_reg | st_set) & mask_reg);
  end

  // Read channel: one read at a time, answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `FCS_RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? `FCS_RESP_OKAY : `FCS_RESP_DECERR;
        unique case (araddr)
          `FCS_OFS_RATIO: rdata <= {24'h0, ratio_loaded_flag, ratio_reg};
          `FCS_OFS_OPTIONS: rdata <= {24'h0, flash_options_working_reg};
          `FCS_OFS_CONFIG: rdata <= {24'h0, flash_config_reg};
          `FCS_OFS_STATUS: rdata <= {29'h0, status_reg};
          `FCS_OFS_MASK: rdata <= {29'h0, mask_reg};
          default: rdata <= 32'h0000_0000;
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // Checks on the block's own behaviour
  sequence s_first_ratio_write;
    wr_lane0 && (aw_addr_reg == `FCS_OFS_RATIO) && !ratio_loaded_flag;
  endsequence

  sequence s_flag_up;
    ratio_loaded_flag && program_erase_enable;
  endsequence

  property p_loaded_sets;
    @(posedge aclk) disable iff (!aresetn) s_first_ratio_write |=> s_flag_up;
  endproperty
  a_loaded_sets: assert property (p_loaded_sets) else $error("loaded flag not set by first write");

  property p_ratio_frozen;
    @(posedge aclk) disable iff (!aresetn) ratio_loaded_flag |=> $stable(ratio_reg) && ratio_loaded_flag;
  endproperty
  a_ratio_frozen: assert property (p_ratio_frozen) else $error("ratio changed after load");

  property p_no_cmd_unloaded;
    @(posedge aclk) disable iff (!aresetn) cmd_write && !ratio_loaded_flag |=> !flash_cmd_start && status_reg[0];
  endproperty
  a_no_cmd_unloaded: assert property (p_no_cmd_unloaded) else $error("command taken before load");

  property p_clk_idle;
    @(posedge aclk) disable iff (!aresetn) !ratio_loaded_flag |-> !flash_clk_pulse;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("flash clock ran before load");

  property p_div_period;
    @(posedge aclk) disable iff (!aresetn)
      flash_clk_pulse && !ratio_reg[6] && (ratio_reg[5:0] == 6'h02) |=> !flash_clk_pulse [*2] ##1 flash_clk_pulse;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divide by three period wrong");

  property p_prescale_period;
    @(posedge aclk) disable iff (!aresetn)
      flash_clk_pulse && ratio_reg[6] && (ratio_reg[5:0] == 6'h00) |=> !flash_clk_pulse [*7] ##1 flash_clk_pulse;
  endproperty
  a_prescale_period: assert property (p_prescale_period) else $error("prescale period wrong");

  property p_pulse_single;
    @(posedge aclk) disable iff (!aresetn) flash_clk_pulse && (ratio_reg[5:0] != 6'h00) |=> !flash_clk_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("timing pulse longer than one cycle");

  property p_no_backdoor;
    @(posedge aclk) disable iff (!aresetn) !flash_options_working_reg[7] |-> !key_match;
  endproperty
  a_no_backdoor: assert property (p_no_backdoor) else $error("unlock with backdoor disabled");

  property p_unlock;
    @(posedge aclk) disable iff (!aresetn) key_match |=> (flash_options_working_reg[1:0] == 2'h2) && !secure_block;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key match did not unlock");

  property p_secure_decode;
    @(posedge aclk) disable iff (!aresetn) aresetn |=> (secure_block == (flash_options_working_reg[1:0] != 2'h2));
  endproperty
  a_secure_decode: assert property (p_secure_decode) else $error("security decode mismatch");

  property p_debug_key;
    @(posedge aclk) disable iff (!aresetn) key_write && background_debug_commands |=> $stable(key_count_reg);
  endproperty
  a_debug_key: assert property (p_debug_key) else $error("debug key write accepted");

  property p_redirect;
    @(posedge aclk) disable iff (!aresetn) aresetn |=> (redirect_enable == !flash_options_working_reg[6]);
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect state wrong");

  property p_steer_cmd;
    @(posedge aclk) disable iff (!aresetn) key_write |=> !flash_cmd_start;
  endproperty
  a_steer_cmd: assert property (p_steer_cmd) else $error("key byte started a command");

  property p_opt_stable;
    @(posedge aclk) disable iff (!aresetn) ##1 $stable(flash_options_working_reg[7:2]);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("option bits moved outside reset");
endmodule
`default_nettype wire

// File: common/fcs_regs.svh
// Register map, field positions, reset values and timing counts of the flash configuration block.
// Assumes a 32-bit AXI4-Lite slave with each register in the low byte of one aligned word.
//
// Notes on behaviour
// - Top bit of clock ratio register is a read-only loaded flag, set by first write.
// - Prescale and ratio fields always readable; only the first write after reset lands.
// - Program and erase are blocked until the loaded flag is set.
// - Prescale bit zero feeds the divider from the bus clock, one feeds bus clock/8.
// - Divider divides its input by the ratio field plus one.
// - Each timing pulse lasts one internal flash clock; operations count whole pulses.
// - Option byte is copied into the working options register during reset only.
// - With backdoor enable clear, key comparison never releases security.
// - Key writes are taken from secured firmware only, never from the debug interface.
// - Eight key bytes in ascending order matching the stored key release security until reset.
// - Redirect disable one turns vector redirection off; zero turns it on.
// - Security code 1:0 means unsecured; every other pattern means secure.
// - While secure, memory access from unsecured sources including debug is blocked.
// - Security code is forced to 1:0 after a key match or a full blank check.
// - Key steer zero makes key-window writes start commands; one makes them key bytes.
// - A command before the ratio register is written raises an access error and is ignored.
// - The write that clears key steer triggers the comparison; a match sets code 1:0.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_OFS_RATIO 8'h00
`define FCS_OFS_OPTIONS 8'h04
`define FCS_OFS_CONFIG 8'h08
`define FCS_OFS_STATUS 8'h0C
`define FCS_OFS_MASK 8'h10
`define FCS_OFS_KEY0 8'h40
`define FCS_OFS_KEY7 8'h5C
`define FCS_BIT_LOADED 7
`define FCS_BIT_PRESCALE 6
`define FCS_BIT_BACKDOOR 7
`define FCS_BIT_REDIRECT 6
`define FCS_BIT_STEER 5
`define FCS_ST_ACCERR 0
`define FCS_ST_UNSEC 1
`define FCS_ST_KEYFAIL 2
`define FCS_RST_RATIO 7'h00
`define FCS_RST_CONFIG 8'h00
`define FCS_RST_MASK 3'h0
`define FCS_SEC_OPEN 2'h2
`define FCS_PRESCALE_DIV 3'h7
`define FCS_KEY_BYTES 4'h8
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_DECERR 2'h3
`endif

// File: common/fcs_pkg.sv
// Types shared by the flash configuration block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package fcs_pkg;
  typedef enum logic [1:0] {KEY_IDLE, KEY_COLLECT, KEY_BROKEN} fcs_key_state_type;
  typedef logic [7:0] fcs_byte_type;
endpackage
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench of the flash configuration block: AXI4-Lite register tasks and directed checks.
// Assumes the constants header, the package and the design are compiled before this file.
`include "fcs_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
  // Design inputs, all given a value at time zero
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [7:0] nonvolatile_option_byte = 8'h00;
  logic [63:0] stored_backdoor_key = KEY;
  logic background_debug_commands = 1'h0;
  logic blank_check_pass = 1'h0;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic flash_cmd_start, program_erase_enable, flash_clk_pulse, secure_block, redirect_enable, irq;
  logic [2:0] flash_cmd_index;
  logic [7:0] flash_cmd_data;
  int error_cnt = 0;
  int comparisons = 0;
  int starts = 0;

  fcs_flash_cfg dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .nonvolatile_option_byte, .stored_backdoor_key, .background_debug_commands, .blank_check_pass,
    .flash_cmd_start, .flash_cmd_index, .flash_cmd_data, .program_erase_enable, .flash_clk_pulse,
    .secure_block, .redirect_enable, .irq
  );

  // 50 MHz bus clock
  always #10 aclk = ~aclk;

  // Count command launches; a pulse is one cycle so each edge sees it once
  always @(posedge aclk)
  begin
    if (flash_cmd_start === 1'h1)
      starts <= starts + 1;
  end

  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    $display("[FAIL] wait bound used up");
    close_out();
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Write one word; both channels offered together, bready held until bvalid is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (awvalid === 1'h1 && awready === 1'h1)
        awvalid <= 1'h0;
      if (wvalid === 1'h1 && wready === 1'h1)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
      begin
        done = 1'h1;
        bready <= 1'h0;
        chk("bresp", 32'(er), 32'(bresp));
      end
      if (n > 50)
        timeout();
    end
    // Let an edge pass so the next request never reassigns in this time step
    @(posedge aclk);
  endtask

  // Read one word and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string name);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (arvalid === 1'h1 && arready === 1'h1)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        done = 1'h1;
        rready <= 1'h0;
        chk(name, exp, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
      if (n > 50)
        timeout();
    end
    @(posedge aclk);
  endtask

  // Hold reset 12 cycles, then disturb the option byte to prove it was latched only in reset
  task automatic do_reset(input logic [7:0] nv);
    aresetn <= 1'h0;
    nonvolatile_option_byte <= nv;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    nonvolatile_option_byte <= ~nv;
  endtask

  // Steer on, eight key bytes in ascending slots, steer off; dbg picks a slot sent from debug
  task automatic key_seq(input logic [63:0] k, input int dbg);
    wr(`FCS_OFS_CONFIG, 32'h20, `FCS_RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      background_debug_commands <= (i == dbg);
      wr(`FCS_OFS_KEY0 + 8'(4 * i), {24'h0, k[63 - 8 * i -: 8]}, `FCS_RESP_OKAY);
    end
    background_debug_commands <= 1'h0;
    wr(`FCS_OFS_CONFIG, 32'h0, `FCS_RESP_OKAY);
  endtask

  // Edges between two flash clock pulses
  task automatic period(input int exp, input string name);
    int n;
    n = 0;
    while (flash_clk_pulse !== 1'h1)
    begin
      @(posedge aclk);
      n++;
      if (n > 600)
        timeout();
    end
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (flash_clk_pulse !== 1'h1 && n < 600);
    chk(name, 32'(exp), 32'(n));
  endtask

  // Main sequence
  initial
  begin
    do_reset(8'h81);
    chk("pe_enable", 32'h0, 32'(program_erase_enable));
    rd(`FCS_OFS_RATIO, 32'h0, `FCS_RESP_OKAY, "ratio");
    rd(`FCS_OFS_OPTIONS, 32'h81, `FCS_RESP_OKAY, "options");
    chk("secure", 32'h1, 32'(secure_block));
    chk("redirect", 32'h1, 32'(redirect_enable));
    rd(8'h20, 32'h0, `FCS_RESP_DECERR, "unmapped");
    wr(8'h24, 32'hFF, `FCS_RESP_DECERR);
    // Command before the ratio is loaded
    wr(8'h44, 32'h11, `FCS_RESP_OKAY);
    @(posedge aclk);
    chk("starts", 32'h0, 32'(starts));
    rd(`FCS_OFS_STATUS, 32'h1, `FCS_RESP_OKAY, "status");
    wr(`FCS_OFS_MASK, 32'h1, `FCS_RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(`FCS_OFS_STATUS, 32'h1, `FCS_RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    rd(`FCS_OFS_STATUS, 32'h0, `FCS_RESP_OKAY, "status");
    // Load once, then try to overwrite; 50 MHz over 8 x 32 is about 195 kHz, in band before any command
    wr(`FCS_OFS_RATIO, 32'h5F, `FCS_RESP_OKAY);
    rd(`FCS_OFS_RATIO, 32'hDF, `FCS_RESP_OKAY, "ratio");
    chk("pe_enable", 32'h1, 32'(program_erase_enable));
    wr(`FCS_OFS_RATIO, 32'h05, `FCS_RESP_OKAY);
    rd(`FCS_OFS_RATIO, 32'hDF, `FCS_RESP_OKAY, "ratio");
    period(256, "period_div8");
    // Command once loaded
    wr(8'h4C, 32'h5A, `FCS_RESP_OKAY);
    @(posedge aclk);
    chk("starts", 32'h1, 32'(starts));
    chk("cmd_index", 32'h3, 32'(flash_cmd_index));
    chk("cmd_data", 32'h5A, 32'(flash_cmd_data));
    // Wrong key, then a key byte from debug, then the right key
    key_seq(KEY ^ 64'h1, -1);
    chk("secure", 32'h1, 32'(secure_block));
    rd(`FCS_OFS_STATUS, 32'h4, `FCS_RESP_OKAY, "status");
    wr(`FCS_OFS_STATUS, 32'h4, `FCS_RESP_OKAY);
    key_seq(KEY, 4);
    chk("secure", 32'h1, 32'(secure_block));
    wr(`FCS_OFS_STATUS, 32'h4, `FCS_RESP_OKAY);
    key_seq(KEY, -1);
    chk("secure", 32'h0, 32'(secure_block));
    rd(`FCS_OFS_STATUS, 32'h2, `FCS_RESP_OKAY, "status");
    rd(`FCS_OFS_OPTIONS, 32'h82, `FCS_RESP_OKAY, "options");
    // Second reset: backdoor off, redirection off, erased code
    do_reset(8'h43);
    rd(`FCS_OFS_OPTIONS, 32'h43, `FCS_RESP_OKAY, "options");
    chk("redirect", 32'h0, 32'(redirect_enable));
    chk("secure", 32'h1, 32'(secure_block));
    rd(`FCS_OFS_RATIO, 32'h0, `FCS_RESP_OKAY, "ratio");
    wr(`FCS_OFS_RATIO, 32'h02, `FCS_RESP_OKAY);
    period(3, "period_div1");
    key_seq(KEY, -1);
    chk("secure", 32'h1, 32'(secure_block));
    blank_check_pass <= 1'h1;
    @(posedge aclk);
    blank_check_pass <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("secure", 32'h0, 32'(secure_block));
    rd(`FCS_OFS_STATUS, 32'h6, `FCS_RESP_OKAY, "status");
    // Third reset: unsecured code straight from the option byte, prescale with ratio zero
    do_reset(8'hC2);
    rd(`FCS_OFS_OPTIONS, 32'hC2, `FCS_RESP_OKAY, "options");
    chk("secure", 32'h0, 32'(secure_block));
    chk("redirect", 32'h0, 32'(redirect_enable));
    wr(`FCS_OFS_RATIO, 32'h40, `FCS_RESP_OKAY);
    period(8, "period_pre0");
    close_out();
  end
endmodule
`default_nettype wire
